/* core/irq_pkg.sv */
package irq_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] ADDR_SYS_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SENSE = 12'h004;
  localparam logic [11:0] ADDR_ENABLE = 12'h008;
  localparam logic [11:0] ADDR_FLAG = 12'h00c;
  localparam logic [11:0] ADDR_PRIO_A = 12'h010;
  localparam logic [11:0] ADDR_PRIO_B = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int NMI_EDGE_POS = 0;
  localparam int MASK_MODE_POS = 1;
  localparam logic [7:0] SYS_CTRL_RST = 8'h02;
  localparam logic [7:0] REG8_RST = 8'h00;
  // ----------------------------------------
  // Sources and vectors
  // ----------------------------------------
  localparam int NUM_PINS = 8;
  localparam int NUM_INT = 34;
  localparam int NUM_VEC = 64;
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_PIN_BASE = 6'h0c;
  localparam int WAKE_PINS = 3;
  // Timer and serial sources may be steered to the DMA unit
  localparam logic [33:0] DMA_ROUTABLE = 34'h1_fe01_fffc;

  function automatic logic [5:0] int_vector(input int idx);
    int v;
    if (idx < 2) v = 20 + idx;
    else if (idx < 17) v = 24 + 4 * ((idx - 2) / 3) + ((idx - 2) % 3);
    else if (idx < 33) v = 44 + (idx - 17);
    else v = 60;
    return 6'(v);
  endfunction : int_vector

  function automatic logic prio_bit(input int v, input logic [7:0] pa, input logic [7:0] pb);
    case (v) inside
      12: return pa[7];
      13: return pa[6];
      [14:15]: return pa[5];
      [16:19]: return pa[4];
      [20:21]: return pa[3];
      [24:27]: return pa[2];
      [28:31]: return pa[1];
      [32:35]: return pa[0];
      [36:39]: return pb[7];
      [40:43]: return pb[6];
      [44:47]: return pb[5];
      [48:51]: return pb[4];
      [52:55]: return pb[3];
      [56:59]: return pb[2];
      60: return pb[1];
      default: return 1'b0;
    endcase
  endfunction : prio_bit
endpackage : irq_pkg

/* core/pin_request_unit.sv */
module pin_request_unit
  import irq_pkg::*;
#(
  parameter int N = NUM_PINS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and control
  input wire logic [N-1:0] pin_n,
  input wire logic [N-1:0] sense,
  input wire logic [N-1:0] clr_sw,
  input wire logic [N-1:0] clr_ack,
  // Status
  output logic [N-1:0] flag_r,
  output logic [N-1:0] low_now
);
  // ----------------------------------------
  // Synchronise, then edge detect
  // ----------------------------------------
  logic [N-1:0] s1_r, s2_r, prev_r;
  logic [N-1:0] set_w, ack_ok_w, flag_nxt;

  assign low_now = ~s2_r;
  genvar i;
  for (i = 0; i < N; i++) begin : g_pin
    assign set_w[i] = sense[i] ? (prev_r[i] & ~s2_r[i]) : ~s2_r[i];
    assign ack_ok_w[i] = clr_ack[i] & (sense[i] | s2_r[i]);
  end
  // Set wins over any clear in the same cycle
  assign flag_nxt = set_w | (flag_r & ~clr_sw & ~ack_ok_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '1;
      s2_r <= '1;
      prev_r <= '1;
      flag_r <= '0;
    end else begin
      s1_r <= pin_n;
      s2_r <= s1_r;
      prev_r <= s2_r;
      flag_r <= flag_nxt;
    end
  end

  for (i = 0; i < N; i++) begin : g_chk
    edge_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      sense[i] && prev_r[i] && !s2_r[i] |=> flag_r[i])
      else $error("falling edge did not set flag");
    level_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      !sense[i] && !s2_r[i] |=> flag_r[i])
      else $error("low level did not set flag");
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      clr_sw[i] && !set_w[i] |=> !flag_r[i])
      else $error("software clear ignored");
  end
endmodule : pin_request_unit

/* core/vector_select.sv */
module vector_select
  import irq_pkg::*;
(
  // Eligible requests and levels
  input wire logic [NUM_VEC-1:0] req,
  input wire logic [NUM_VEC-1:0] lvl,
  // Winner
  output logic found,
  output logic [5:0] vec
);
  // Level 1 first, then smallest vector number
  logic hi_f, lo_f;
  logic [5:0] hi_v, lo_v;

  always_comb begin
    hi_f = 1'b0;
    lo_f = 1'b0;
    hi_v = '0;
    lo_v = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (req[v] && lvl[v]) begin
        hi_f = 1'b1;
        hi_v = 6'(v);
      end
      if (req[v] && !lvl[v]) begin
        lo_f = 1'b1;
        lo_v = 6'(v);
      end
    end
  end
  assign found = hi_f | lo_f;
  assign vec = hi_f ? hi_v : lo_v;
endmodule : vector_select

/* core/interrupt_source_vector_priority.sv */
module interrupt_source_vector_priority
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic nmi_pin,
  input wire logic [NUM_PINS-1:0] irq_pin_n,
  // Internal peripheral requests
  input wire logic [NUM_INT-1:0] int_flag,
  input wire logic [NUM_INT-1:0] int_enable,
  input wire logic [NUM_INT-1:0] dma_route,
  // Core side
  input wire logic global_mask_bit,
  input wire logic user_mask_bit,
  input wire logic core_ack,
  input wire logic standby_mode,
  output logic irq_req,
  output logic [5:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic wake,
  output logic [NUM_INT-1:0] dma_trigger
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] sys_ctrl_r, sense_r, pin_en_r, prio_a_r, prio_b_r;
  logic [7:0] read_one_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic irq_req_r, wake_r;
  logic [5:0] vector_r;
  logic [15:0] vector_addr_r;
  logic [NUM_INT-1:0] dma_trigger_r;
  logic nmi_s1_r, nmi_s2_r, nmi_prev_r, nmi_pend_r;

  typedef enum logic [1:0] {ST_IDLE, ST_PRESENT, ST_GAP} state_e;
  state_e state_r, state_nxt;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire access_w = psel & penable & ~pready_r;
  wire done_w = psel & penable & pready_r;
  wire wr_w = done_w & pwrite;
  wire hit_sys = (paddr == ADDR_SYS_CTRL);
  wire hit_sense = (paddr == ADDR_SENSE);
  wire hit_en = (paddr == ADDR_ENABLE);
  wire hit_flag = (paddr == ADDR_FLAG);
  wire hit_pa = (paddr == ADDR_PRIO_A);
  wire hit_pb = (paddr == ADDR_PRIO_B);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire mapped_w = hit_sys | hit_sense | hit_en | hit_flag | hit_pa | hit_pb | hit_stat;

  wire [7:0] pin_flag_w;
  wire [7:0] status_w = {irq_req_r, 1'b0, vector_r};
  wire [7:0] rd_byte_w = hit_sys ? sys_ctrl_r :
                         hit_sense ? sense_r :
                         hit_en ? pin_en_r :
                         hit_flag ? pin_flag_w :
                         hit_pa ? prio_a_r :
                         hit_pb ? prio_b_r :
                         hit_stat ? status_w : 8'h00;

  // Only flags seen as one by a read may be cleared by a zero write
  wire [7:0] clr_sw_w = (wr_w & hit_flag) ? (read_one_r & ~pwdata[7:0]) : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= access_w;
      pslverr_r <= access_w & ~mapped_w;
      prdata_r <= access_w ? {24'h000000, rd_byte_w} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ctrl_r <= SYS_CTRL_RST;
      sense_r <= REG8_RST;
      pin_en_r <= REG8_RST;
      prio_a_r <= REG8_RST;
      prio_b_r <= REG8_RST;
      read_one_r <= REG8_RST;
    end else begin
      if (wr_w && hit_sys) sys_ctrl_r <= pwdata[7:0] & 8'h03;
      if (wr_w && hit_sense) sense_r <= pwdata[7:0];
      if (wr_w && hit_en) pin_en_r <= pwdata[7:0];
      if (wr_w && hit_pa) prio_a_r <= pwdata[7:0];
      if (wr_w && hit_pb) prio_b_r <= pwdata[7:0];
      if (access_w && !pwrite && hit_flag) read_one_r <= pin_flag_w;
      else if (wr_w && hit_flag) read_one_r <= REG8_RST;
    end
  end

  // ----------------------------------------
  // NMI edge detection
  // ----------------------------------------
  wire nmi_rising = sys_ctrl_r[NMI_EDGE_POS];
  wire nmi_edge_w = nmi_rising ? (nmi_s2_r & ~nmi_prev_r) : (~nmi_s2_r & nmi_prev_r);
  wire ack_fire_w = (state_r == ST_PRESENT) & core_ack;
  wire nmi_ack_w = ack_fire_w & (vector_r == VEC_NMI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_prev_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_prev_r <= nmi_s2_r;
      nmi_pend_r <= nmi_edge_w | (nmi_pend_r & ~nmi_ack_w);
    end
  end

  // ----------------------------------------
  // External pins
  // ----------------------------------------
  wire [7:0] pin_ack_w;
  genvar i;
  for (i = 0; i < NUM_PINS; i++) begin : g_pin_ack
    assign pin_ack_w[i] = ack_fire_w & (vector_r == VEC_PIN_BASE + 6'(i));
  end

  pin_request_unit #(.N(NUM_PINS)) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pin_n(irq_pin_n),
    .sense(sense_r),
    .clr_sw(clr_sw_w),
    .clr_ack(pin_ack_w),
    .flag_r(pin_flag_w),
    .low_now()
  );

  // ----------------------------------------
  // Request and level vectors
  // ----------------------------------------
  logic [NUM_VEC-1:0] req_w, lvl_w, elig_w;
  wire [NUM_INT-1:0] int_act_w = int_flag & int_enable;
  wire [NUM_INT-1:0] to_dma_w = int_act_w & dma_route & DMA_ROUTABLE;
  wire [NUM_INT-1:0] to_ctl_w = int_act_w & ~to_dma_w;
  wire alt_mode = ~sys_ctrl_r[MASK_MODE_POS];

  for (i = 0; i < NUM_VEC; i++) begin : g_vec
    logic pin_hit, int_hit;
    always_comb begin
      pin_hit = 1'b0;
      int_hit = 1'b0;
      for (int p = 0; p < NUM_PINS; p++) begin
        if (i == int'(VEC_PIN_BASE) + p) pin_hit = pin_flag_w[p] & pin_en_r[p];
      end
      for (int k = 0; k < NUM_INT; k++) begin
        if (6'(i) == int_vector(k)) int_hit = to_ctl_w[k];
      end
    end
    if (i == int'(VEC_NMI)) begin : g_nmi
      assign req_w[i] = nmi_pend_r;
      assign lvl_w[i] = 1'b1;
      assign elig_w[i] = req_w[i];
    end else begin : g_src
      assign req_w[i] = pin_hit | int_hit;
      assign lvl_w[i] = prio_bit(i, prio_a_r, prio_b_r);
      assign elig_w[i] = req_w[i] & (~global_mask_bit | (alt_mode & ~user_mask_bit & lvl_w[i]));
    end
  end

  wire found_w;
  wire [5:0] win_w;
  vector_select u_select (
    .req(elig_w),
    .lvl(lvl_w),
    .found(found_w),
    .vec(win_w)
  );

  // ----------------------------------------
  // Core handshake
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (found_w) state_nxt = ST_PRESENT;
      ST_PRESENT: if (core_ack) state_nxt = ST_GAP;
      // Gap lets the acked source drop before reselecting
      ST_GAP: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire take_w = (state_r == ST_IDLE) & found_w;
  wire [7:0] wake_src_w = {5'b00000, pin_flag_w[WAKE_PINS-1:0] & pin_en_r[WAKE_PINS-1:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      irq_req_r <= 1'b0;
      vector_r <= '0;
      vector_addr_r <= '0;
      wake_r <= 1'b0;
      dma_trigger_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (take_w) begin
        irq_req_r <= 1'b1;
        vector_r <= win_w;
        vector_addr_r <= {8'h00, win_w, 2'b00};
      end else if (ack_fire_w) begin
        irq_req_r <= 1'b0;
      end
      wake_r <= standby_mode & (nmi_pend_r | (|wake_src_w));
      dma_trigger_r <= to_dma_w;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign irq_vector = vector_r;
  assign irq_vector_addr = vector_addr_r;
  assign wake = wake_r;
  assign dma_trigger = dma_trigger_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  nmi_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE && nmi_pend_r |=> irq_req_r && irq_vector == VEC_NMI)
    else $error("pending NMI not presented first");
  vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req_r |-> irq_vector_addr == {8'h00, vector_r, 2'b00})
    else $error("vector address not number times four");
  req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req_r && !core_ack |=> irq_req_r && $stable(vector_r))
    else $error("request dropped before acknowledge");
  mask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE && !nmi_pend_r && global_mask_bit && (!alt_mode || user_mask_bit)
    |=> !irq_req_r)
    else $error("masked request presented");
  // Checked at selection, where the enable that gated the choice still stands
  pin_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_w && win_w >= VEC_PIN_BASE && win_w < VEC_PIN_BASE + 6'h08
    |-> pin_en_r[3'(win_w - VEC_PIN_BASE)])
    else $error("disabled pin presented");
  wake_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !standby_mode |=> !wake)
    else $error("wake outside standby");
  wake_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    standby_mode && (|wake_src_w) |=> wake)
    else $error("enabled wake pin ignored in standby");
  mask_alt_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_w && global_mask_bit |-> win_w == VEC_NMI || (alt_mode && !user_mask_bit && lvl_w[win_w]))
    else $error("masked source selected");
  select_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_w && !lvl_w[win_w] |-> (elig_w & lvl_w) == '0)
    else $error("level 0 chosen over level 1");
  ack_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_fire_w |=> !irq_req_r ##1 !irq_req_r)
    else $error("request not withdrawn after acknowledge");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_w |=> pready_r)
    else $error("access not answered");
  bus_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_w && !mapped_w |=> pslverr_r && prdata_r == 32'h00000000)
    else $error("unmapped access not flagged");
  prio_a_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_pa |=> prio_a_r == $past(pwdata[7:0]))
    else $error("priority a write lost");
  prio_b_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_pb |=> prio_b_r == $past(pwdata[7:0]))
    else $error("priority b write lost");
  sense_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_sense |=> sense_r == $past(pwdata[7:0]))
    else $error("sense write lost");
  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_en |=> pin_en_r == $past(pwdata[7:0]))
    else $error("enable write lost");

  // ----------------------------------------
  // Source checks
  // ----------------------------------------
  nmi_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_edge_w |=> nmi_pend_r)
    else $error("selected edge did not raise NMI");
  nmi_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_ack_w && !nmi_edge_w |=> !nmi_pend_r)
    else $error("NMI pending after acknowledge");
  dma_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> dma_trigger == $past(int_flag & int_enable & dma_route & DMA_ROUTABLE))
    else $error("DMA trigger does not follow routed sources");
  // Routed sources must never reach the selector
  for (i = 0; i < NUM_INT; i++) begin : g_dma_chk
    dma_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
      to_dma_w[i] |-> !req_w[int_vector(i)])
      else $error("routed source reached selector");
  end
endmodule : interrupt_source_vector_priority

/* sim/core_model.sv */
module core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire logic irq_req,
  input wire logic [5:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  // Answer delay
  input wire logic [3:0] dly,
  // Acknowledge and log
  output logic core_ack,
  output logic [5:0] got_vec,
  output logic [15:0] got_addr,
  output logic [7:0] got_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  logic [3:0] wait_r;
  // One-cycle ack after a chosen wait; a slow core lets pins settle first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      wait_r <= 4'h0;
      got_vec <= 6'h00;
      got_addr <= 16'h0000;
      got_cnt <= 8'h00;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      got_vec <= irq_vector;
      got_addr <= irq_vector_addr;
      got_cnt <= got_cnt + 8'h01;
    end else if (irq_req && wait_r == dly) begin
      core_ack <= 1'b1;
      wait_r <= 4'h0;
    end else if (irq_req) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule : core_model

/* sim/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, nmi_pin, global_mask_bit, user_mask_bit, standby_mode;
  logic pready, pslverr, core_ack, irq_req, wake, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_PINS-1:0] irq_pin_n;
  logic [NUM_INT-1:0] int_flag, int_enable, dma_route, dma_trigger;
  logic [5:0] irq_vector, got_vec;
  logic [15:0] irq_vector_addr, got_addr;
  logic [7:0] got_cnt;
  logic [3:0] dly;
  int num_errors, checked;

  interrupt_source_vector_priority u_interrupt_source_vector_priority (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .nmi_pin, .irq_pin_n, .int_flag, .int_enable, .dma_route,
    .global_mask_bit, .user_mask_bit, .core_ack, .standby_mode, .irq_req, .irq_vector, .irq_vector_addr, .wake,
    .dma_trigger);
  core_model u_core_model (.pclk, .presetn, .irq_req, .irq_vector, .irq_vector_addr, .dly, .core_ack, .got_vec,
    .got_addr, .got_cnt);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 10);
    chk(34'(pready), 34'h1, "apb ready");
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(34'(rd), 34'(e), m);
  endtask : rchk

  task automatic take(input logic [5:0] v);
    logic [7:0] c;
    int n;
    c = got_cnt;
    n = 0;
    while (got_cnt === c && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk(34'(n < 80), 34'h1, "acceptance in time");
    chk(34'(got_vec), 34'(v), "vector");
    chk(34'(got_addr), 34'({v, 2'b00}), "vector address");
  endtask : take

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge pclk);
      chk(34'(irq_req), 34'h0, "no request");
    end
  endtask : quiet
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk(ADDR_SYS_CTRL, 32'(SYS_CTRL_RST), "sys ctrl reset");
    for (int i = 1; i < 7; i++) rchk(12'(4 * i), 32'h0, "reg reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(34'(err_seen), 34'h1, "unmapped");
    apb(1'b1, ADDR_PRIO_A, 32'ha5);
    rchk(ADDR_PRIO_A, 32'ha5, "prio a rw");
    apb(1'b1, ADDR_PRIO_A, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Pin 5 edge, pin 6 level, both disabled
  task automatic t_flags;
    apb(1'b1, ADDR_SENSE, 32'h20);
    irq_pin_n <= 8'h9f;
    quiet(6);
    rchk(ADDR_FLAG, 32'h60, "flags set");
    apb(1'b1, ADDR_FLAG, 32'h0);
    rchk(ADDR_FLAG, 32'h40, "level flag held");
    irq_pin_n <= 8'hff;
    cyc(4);
    apb(1'b1, ADDR_FLAG, 32'h0);
    rchk(ADDR_FLAG, 32'h0, "flags cleared");
    apb(1'b1, ADDR_SENSE, 32'h0);
    $display("test flags done");
  endtask : t_flags

  task automatic t_pins;
    standby_mode <= 1'b1;
    global_mask_bit <= 1'b1;
    apb(1'b1, ADDR_ENABLE, 32'h19);
    irq_pin_n <= 8'hf7;
    cyc(6);
    chk(34'(wake), 34'h0, "pin 3 woke");
    irq_pin_n <= 8'he6;
    cyc(6);
    chk(34'(wake), 34'h1, "pin 0 no wake");
    irq_pin_n <= 8'hff;
    standby_mode <= 1'b0;
    cyc(4);
    global_mask_bit <= 1'b0;
    take(6'd12);
    take(6'd15);
    take(6'd16);
    apb(1'b1, ADDR_PRIO_A, 32'h10);
    global_mask_bit <= 1'b1;
    irq_pin_n <= 8'hee;
    cyc(6);
    irq_pin_n <= 8'hff;
    cyc(4);
    global_mask_bit <= 1'b0;
    take(6'd16);
    take(6'd12);
    apb(1'b1, ADDR_PRIO_A, 32'h0);
    $display("test pins done");
  endtask : t_pins

  task automatic t_nmi;
    global_mask_bit <= 1'b1;
    user_mask_bit <= 1'b1;
    apb(1'b1, ADDR_SYS_CTRL, 32'h03);
    nmi_pin <= 1'b1;
    take(VEC_NMI);
    nmi_pin <= 1'b0;
    quiet(8);
    apb(1'b1, ADDR_SYS_CTRL, 32'h02);
    nmi_pin <= 1'b1;
    quiet(8);
    nmi_pin <= 1'b0;
    take(VEC_NMI);
    user_mask_bit <= 1'b0;
    $display("test nmi done");
  endtask : t_nmi

  // Sources 33 (level 1), 17 (level 0), 2 (steered to DMA)
  task automatic t_internal;
    dly <= 4'd0;
    apb(1'b1, ADDR_SYS_CTRL, 32'h00);
    apb(1'b1, ADDR_PRIO_B, 32'h02);
    global_mask_bit <= 1'b1;
    int_flag <= 34'h2_0002_0004;
    dma_route <= 34'h4;
    quiet(6);
    int_enable <= 34'h2_0002_0004;
    take(6'd60);
    int_flag[33] <= 1'b0;
    chk(dma_trigger, 34'h4, "dma steering");
    quiet(8);
    global_mask_bit <= 1'b0;
    take(6'd44);
    int_flag[17] <= 1'b0;
    dma_route <= '0;
    take(6'd24);
    chk(dma_trigger, 34'h0, "dma released");
    int_flag <= '0;
    $display("test internal done");
  endtask : t_internal
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict;
  end

  initial begin
    {presetn, psel, penable, pwrite, nmi_pin, global_mask_bit, user_mask_bit, standby_mode} = '0;
    paddr = '0;
    pwdata = '0;
    irq_pin_n = '1;
    int_flag = '0;
    int_enable = '0;
    dma_route = '0;
    dly = 4'd6;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_flags;
    t_pins;
    t_nmi;
    t_internal;
    print_verdict;
  end
endmodule : testbench
